// ---- uart_rx_pkg.sv ----
// shared constants and types for the serial receiver
package uart_rx_pkg;

	// register byte offsets on the avalon slave
	localparam logic [4:0] OFS_RX_STAT_CTRL = 5'h00;
	localparam logic [4:0] OFS_RX_BUFFER = 5'h04;
	localparam logic [4:0] OFS_TX_STAT_CTRL = 5'h08;
	localparam logic [4:0] OFS_BAUD_CTRL = 5'h0C;
	localparam logic [4:0] OFS_DIV_HIGH = 5'h10;
	localparam logic [4:0] OFS_DIV_LOW = 5'h14;
	localparam logic [4:0] OFS_IRQ_CTRL = 5'h18;

	// receive_status_control fields
	localparam int unsigned SERIAL_PORT_ENABLE_BIT = 7;
	localparam int unsigned NINE_BIT_RECEIVE_SELECT_BIT = 6;
	localparam int unsigned SINGLE_RECEIVE_ENABLE_BIT = 5;
	localparam int unsigned CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
	localparam int unsigned ADDRESS_DETECT_ENABLE_BIT = 3;
	localparam int unsigned FRAMING_ERROR_FLAG_BIT = 2;
	localparam int unsigned OVERRUN_ERROR_FLAG_BIT = 1;
	localparam int unsigned RECEIVED_NINTH_BIT_BIT = 0;

	// transmit_status_control fields used here
	localparam int unsigned CLOCKED_MODE_SELECT_BIT = 4;
	localparam int unsigned HIGH_RATE_PRESCALE_SELECT_BIT = 2;

	// baud_control fields
	localparam int unsigned RECEIVER_IDLE_STATUS_BIT = 6;
	localparam int unsigned WIDE_DIVISOR_SELECT_BIT = 3;
	localparam int unsigned WAKE_ON_EDGE_ENABLE_BIT = 1;
	localparam logic [7:0] BAUD_CTRL_STORE_MASK = 8'h39;

	// interrupt control fields
	localparam int unsigned RECEIVE_INTERRUPT_ENABLE_BIT = 0;
	localparam int unsigned RECEIVE_COMPLETE_FLAG_BIT = 1;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// oversampling and framing
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [1:0] PRESCALE_SLOW = 2'h3;

	// receive buffer holds two words
	localparam logic [1:0] BUF_FULL = 2'h2;

	// one received word with its own status
	typedef struct packed {
		logic ninth;
		logic frame_err;
		logic [7:0] data;
	} rx_word_s;

	// receive sequencer states
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_e;

endpackage

// ---- baud_tick_gen.sv ----
`timescale 1ns/1ps
// sixteen-times oversampling tick from the divisor pair
module baud_tick_gen import uart_rx_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [15:0] i_divisor,
	input wire logic i_slow,
	output logic o_tick
);

	logic [1:0] pre_q; // coarse prescale stage
	logic [15:0] cnt_q; // divisor counter
	logic pre_wrap_w;
	logic cnt_wrap_w;

	// prescale by four only in the slow setting
	assign pre_wrap_w = !i_slow || (pre_q == PRESCALE_SLOW);
	// compare with >= so a divisor shrunk on the fly cannot strand the counter
	assign cnt_wrap_w = pre_wrap_w && (cnt_q >= i_divisor);

	// counters halt and clear while stopped, so the first tick is a full period
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_q <= 2'h0;
			cnt_q <= 16'h0000;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			pre_q <= 2'h0;
			cnt_q <= 16'h0000;
			o_tick <= 1'b0;
		end else begin
			o_tick <= cnt_wrap_w;
			pre_q <= pre_wrap_w ? 2'h0 : pre_q + 2'h1;
			if (pre_wrap_w) begin
				cnt_q <= cnt_wrap_w ? 16'h0000 : cnt_q + 16'h0001;
			end
		end
	end

endmodule

// ---- uart_rx_top.sv ----
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - sample line at sixteen ticks per bit
// - frames received only while continuous enable set
// - complete flag set; interrupt only when enabled
// - ninth bit received and shown at bit zero
// - buffer read returns oldest byte, removes it
// - third word with two unread sets overrun
// - clearing continuous enable clears error flags
// - address detect withholds non-address nine-bit words
// - no baud ticks or reception while asleep
// - wake enable suspends reception, watches the line
// - falling line edge under wake enable wakes outside clocked mode
// - wake event sets the receive complete flag
// - buffer read clears the wake interrupt condition
// - next rising edge clears wake enable itself
// - frame is start, eight/nine data, stop
// - data arrives least significant bit first
module uart_rx_top import uart_rx_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic i_serial_receive_line,
	input wire logic i_sleep,
	output logic o_rx_irq,
	output logic o_wake_req
);

	// software-visible control storage
	logic [7:0] rx_ctrl_q; // only bits 7..3 are stored
	logic [7:0] tx_ctrl_q;
	logic [7:0] baud_ctrl_q; // stored bits per mask, wake bit kept apart
	logic wake_enable_q;
	logic [7:0] div_high_q;
	logic [7:0] div_low_q;
	logic rx_irq_enable_q;

	// bus slave state
	logic wait_q; // idles high, drops for the completing edge
	logic [31:0] readdata_q;

	// receive line synchroniser and edge history
	logic line_meta_q; // first stage, read only by line_sync_q
	logic line_sync_q;
	logic line_prev_q;

	// receive sequencer
	rx_state_e state_q;
	logic [3:0] tick_cnt_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] shift_q;

	// two-word buffer
	rx_word_s mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic overrun_q;

	// wake tracking
	logic wake_flag_q; // pending wake interrupt condition
	logic wake_armed_q; // falling edge seen, waiting for rising edge

	// output flops
	logic rx_irq_q;
	logic wake_req_q;

	// decoded control fields
	logic port_en_w;
	logic nine_w;
	logic cont_en_w;
	logic addr_det_w;
	logic clocked_mode_w;
	logic wide_div_w;
	logic high_rate_w;
	assign port_en_w = rx_ctrl_q[SERIAL_PORT_ENABLE_BIT];
	assign nine_w = rx_ctrl_q[NINE_BIT_RECEIVE_SELECT_BIT];
	assign cont_en_w = rx_ctrl_q[CONTINUOUS_RECEIVE_ENABLE_BIT];
	assign addr_det_w = rx_ctrl_q[ADDRESS_DETECT_ENABLE_BIT];
	assign clocked_mode_w = tx_ctrl_q[CLOCKED_MODE_SELECT_BIT];
	assign wide_div_w = baud_ctrl_q[WIDE_DIVISOR_SELECT_BIT];
	assign high_rate_w = tx_ctrl_q[HIGH_RATE_PRESCALE_SELECT_BIT];

	// bus decode
	logic req_w;
	logic rd_done_w;
	logic wr_done_w;
	logic sel_stat_w;
	logic sel_buf_w;
	logic sel_tx_w;
	logic sel_baud_w;
	logic sel_hi_w;
	logic sel_lo_w;
	logic sel_irq_w;
	logic [7:0] wbyte_w;
	assign req_w = i_read || i_write;
	assign rd_done_w = i_read && !wait_q;
	// only the low lane carries a register; other lanes are ignored
	assign wr_done_w = i_write && !wait_q && i_byteenable[0];
	assign sel_stat_w = i_address == OFS_RX_STAT_CTRL;
	assign sel_buf_w = i_address == OFS_RX_BUFFER;
	assign sel_tx_w = i_address == OFS_TX_STAT_CTRL;
	assign sel_baud_w = i_address == OFS_BAUD_CTRL;
	assign sel_hi_w = i_address == OFS_DIV_HIGH;
	assign sel_lo_w = i_address == OFS_DIV_LOW;
	assign sel_irq_w = i_address == OFS_IRQ_CTRL;
	assign wbyte_w = i_writedata[7:0];

	// reception gating
	logic rx_run_w;
	logic baud_run_w;
	logic tick_w;
	logic [15:0] divisor_w;
	// wake enable parks the sequencer; sleep stops the baud ticks and the sequencer
	assign rx_run_w = port_en_w && cont_en_w && !clocked_mode_w && !wake_enable_q
		&& !i_sleep;
	assign baud_run_w = port_en_w && !i_sleep;
	// eight-bit divisor mode ignores the high byte
	assign divisor_w = wide_div_w ? {div_high_q, div_low_q} : {8'h00, div_low_q};

	baud_tick_gen u_baud (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_run(baud_run_w),
		.i_divisor(divisor_w),
		.i_slow(!(wide_div_w || high_rate_w)),
		.o_tick(tick_w)
	);

	// sequencer decode
	logic [3:0] nbits_w;
	logic bit_tick_w;
	logic push_w;
	rx_word_s word_w;
	logic accept_w;
	assign nbits_w = nine_w ? BITS_NINE : BITS_EIGHT;
	assign bit_tick_w = tick_w && (tick_cnt_q == TICK_LAST);
	assign push_w = (state_q == RX_STOP) && bit_tick_w;
	// eight-bit frames leave the byte in the upper bits of the shifter
	assign word_w.data = nine_w ? shift_q[7:0] : shift_q[8:1];
	assign word_w.ninth = nine_w && shift_q[8];
	assign word_w.frame_err = !line_sync_q;
	// a non-address word is dropped silently under address detect
	assign accept_w = push_w && !(addr_det_w && nine_w && !word_w.ninth);

	// buffer decode
	logic pop_w;
	logic buf_read_w;
	logic full_w;
	logic store_w;
	logic overrun_set_w;
	logic [1:0] count_d;
	rx_word_s head_w;
	assign buf_read_w = rd_done_w && sel_buf_w;
	assign pop_w = buf_read_w && (count_q != 2'h0);
	assign full_w = count_q == BUF_FULL;
	// a pop in the same cycle frees the slot, so no overrun then
	assign store_w = accept_w && (!full_w || pop_w);
	assign overrun_set_w = accept_w && full_w && !pop_w;
	assign count_d = count_q + {1'b0, store_w} - {1'b0, pop_w};
	assign head_w = mem_q[rd_ptr_q];

	// wake edge decode, taken from the synchronised line only
	logic fall_w;
	logic rise_w;
	logic wake_evt_w;
	logic wake_end_w;
	assign fall_w = line_prev_q && !line_sync_q;
	assign rise_w = !line_prev_q && line_sync_q;
	assign wake_evt_w = wake_enable_q && !clocked_mode_w && !wake_armed_q && fall_w;
	assign wake_end_w = wake_enable_q && wake_armed_q && rise_w;

	// status views
	logic rx_idle_w;
	logic complete_w;
	logic [7:0] stat_rd_w;
	logic [7:0] baud_rd_w;
	logic [7:0] irq_rd_w;
	logic [7:0] rd_val_w;
	assign rx_idle_w = state_q == RX_IDLE;
	assign complete_w = (count_q != 2'h0) || wake_flag_q;
	assign stat_rd_w = {rx_ctrl_q[7:3], (count_q != 2'h0) && head_w.frame_err,
		overrun_q, (count_q != 2'h0) && head_w.ninth};
	assign baud_rd_w = {1'b0, rx_idle_w, baud_ctrl_q[5:3], 1'b0, wake_enable_q,
		baud_ctrl_q[0]};
	assign irq_rd_w = {6'h00, complete_w, rx_irq_enable_q};
	// unmapped offsets read as zero
	assign rd_val_w = sel_stat_w ? stat_rd_w :
		sel_buf_w ? head_w.data :
		sel_tx_w ? tx_ctrl_q :
		sel_baud_w ? baud_rd_w :
		sel_hi_w ? div_high_q :
		sel_lo_w ? div_low_q :
		sel_irq_w ? irq_rd_w : 8'h00;

	// next wake-enable: a software write beats the self-clear
	logic wake_enable_d;
	assign wake_enable_d = (wr_done_w && sel_baud_w) ? wbyte_w[WAKE_ON_EDGE_ENABLE_BIT] :
		(wake_end_w ? 1'b0 : wake_enable_q);

	// bus handshake: every access takes exactly one wait cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= !(req_w && wait_q);
			if (i_read && wait_q) begin
				readdata_q <= {24'h00_0000, rd_val_w};
			end
		end
	end

	// software-written registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_ctrl_q <= REG_RESET;
			tx_ctrl_q <= REG_RESET;
			baud_ctrl_q <= REG_RESET;
			div_high_q <= REG_RESET;
			div_low_q <= REG_RESET;
			rx_irq_enable_q <= 1'b0;
		end else if (wr_done_w) begin
			// status bits below bit 3 are hardware-owned
			if (sel_stat_w) begin
				rx_ctrl_q <= {wbyte_w[7:3], 3'h0};
			end
			if (sel_tx_w) begin
				tx_ctrl_q <= wbyte_w;
			end
			if (sel_baud_w) begin
				baud_ctrl_q <= wbyte_w & BAUD_CTRL_STORE_MASK;
			end
			if (sel_hi_w) begin
				div_high_q <= wbyte_w;
			end
			if (sel_lo_w) begin
				div_low_q <= wbyte_w;
			end
			if (sel_irq_w) begin
				rx_irq_enable_q <= wbyte_w[RECEIVE_INTERRUPT_ENABLE_BIT];
			end
		end
	end

	// two-flop synchroniser plus one edge-history flop
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			line_meta_q <= 1'b1;
			line_sync_q <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			line_meta_q <= i_serial_receive_line;
			line_sync_q <= line_meta_q;
			line_prev_q <= line_sync_q;
		end
	end

	// frame sequencer; drops back to idle whenever reception is gated off
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= RX_IDLE;
			tick_cnt_q <= 4'h0;
			bit_cnt_q <= 4'h0;
			shift_q <= 9'h000;
		end else if (!rx_run_w) begin
			state_q <= RX_IDLE;
			tick_cnt_q <= 4'h0;
		end else if (tick_w) begin
			unique case (state_q)
				RX_IDLE: begin
					// low line on a tick is a start candidate
					if (!line_sync_q) begin
						state_q <= RX_START;
						tick_cnt_q <= 4'h0;
					end
				end
				RX_START: begin
					// confirm at mid-bit to reject glitches
					if (tick_cnt_q == TICK_MID) begin
						state_q <= line_sync_q ? RX_IDLE : RX_DATA;
						tick_cnt_q <= 4'h0;
						bit_cnt_q <= 4'h0;
					end else begin
						tick_cnt_q <= tick_cnt_q + 4'h1;
					end
				end
				RX_DATA: begin
					// one shift per bit, at the centre of each bit
					tick_cnt_q <= tick_cnt_q + 4'h1;
					if (tick_cnt_q == TICK_LAST) begin
						shift_q <= {line_sync_q, shift_q[8:1]};
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == nbits_w - 4'h1) begin
							state_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					// stop sample closes the frame
					tick_cnt_q <= tick_cnt_q + 4'h1;
					if (tick_cnt_q == TICK_LAST) begin
						state_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// buffer storage; clearing continuous enable also wipes stored error marks
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!cont_en_w) begin
					mem_q[i].frame_err <= 1'b0;
				end
			end
			if (store_w) begin
				mem_q[wr_ptr_q] <= word_w;
			end
		end
	end

	// buffer pointers and overrun; set wins over the enable-clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
			overrun_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ store_w;
			rd_ptr_q <= rd_ptr_q ^ pop_w;
			count_q <= count_d;
			overrun_q <= overrun_set_w || (overrun_q && cont_en_w);
		end
	end

	// wake tracking: event sets the flag, a buffer read clears it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wake_enable_q <= 1'b0;
			wake_armed_q <= 1'b0;
			wake_flag_q <= 1'b0;
		end else begin
			wake_enable_q <= wake_enable_d;
			wake_armed_q <= wake_enable_d && (wake_evt_w || wake_armed_q);
			wake_flag_q <= wake_evt_w || (wake_flag_q && !buf_read_w);
		end
	end

	// registered outputs
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_irq_q <= 1'b0;
			wake_req_q <= 1'b0;
		end else begin
			rx_irq_q <= complete_w && rx_irq_enable_q;
			wake_req_q <= wake_flag_q;
		end
	end

	assign o_readdata = readdata_q;
	assign o_waitrequest = wait_q;
	assign o_rx_irq = rx_irq_q;
	assign o_wake_req = wake_req_q;

endmodule

// ---- uart_rx_monitor.sv ----
`timescale 1ns/1ps
// bus and wake checks on the receiver ports
module uart_rx_monitor import uart_rx_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	input wire logic i_serial_receive_line,
	input wire logic o_rx_irq,
	input wire logic o_wake_req
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	wire wr_done = i_write && !o_waitrequest && i_byteenable[0]; // write lands
	wire rd_done = i_read && !o_waitrequest; // read data taken
	wire unmapped = (i_address[1:0] != 2'h0) || (i_address > OFS_IRQ_CTRL); // holes
	logic ie_q; // interrupt enable as software left it
	logic [7:0] ctl_q; // control byte as software left it
	logic [2:0] low_age_q; // cycles since line low, saturates at 7
	// mirrors kept from completed writes only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ie_q <= 1'b0;
			ctl_q <= 8'h00;
			low_age_q <= 3'h7;
		end else begin
			if (wr_done && i_address == OFS_IRQ_CTRL) ie_q <= i_writedata[0];
			if (wr_done && i_address == OFS_RX_STAT_CTRL) ctl_q <= i_writedata[7:0];
			low_age_q <= !i_serial_receive_line ? 3'h0 : low_age_q + {2'h0, low_age_q != 3'h7};
		end
	end
	sequence s_buf_pop;
		rd_done && i_address == OFS_RX_BUFFER;
	endsequence
	// a wake set needs a recent low, so a quiet line means none can follow
	sequence s_line_quiet;
		low_age_q == 3'h7;
	endsequence
	a_wait_one_cycle: assert property ((i_read || i_write) && o_waitrequest
		|=> !o_waitrequest)
		else $error("waitrequest did not drop after one cycle");
	a_wait_single_pulse: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_upper_bytes_zero: assert property (rd_done |-> o_readdata[31:8] == 24'h0)
		else $error("read data upper bytes not zero");
	a_hole_reads_zero: assert property (rd_done && unmapped |-> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_bits_back: assert property (rd_done && i_address == OFS_RX_STAT_CTRL
		|-> o_readdata[7:3] == ctl_q[7:3])
		else $error("control bits read back wrong");
	a_irq_needs_enable: assert property (o_rx_irq |-> $past(ie_q))
		else $error("interrupt raised while disabled");
	a_wake_read_clears: assert property (s_buf_pop ##0 s_line_quiet |-> ##2 !o_wake_req)
		else $error("buffer read left wake pending");
	a_wake_after_fall: assert property ($rose(o_wake_req) |-> low_age_q < 3'h6)
		else $error("wake raised without a line fall");
endmodule
bind uart_rx_top uart_rx_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
	.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.i_serial_receive_line(i_serial_receive_line), .o_rx_irq(o_rx_irq), .o_wake_req(o_wake_req));

// ---- serial_tx_model.sv ----
`timescale 1ns/1ps
// remote transmitter on the serial line, idles at mark
module serial_tx_model #(parameter int BIT_CLKS = 32) (
	input wire logic i_sys_clk,
	output logic o_line
);
	initial o_line = 1'b1; // idle high between frames
	// start, data lsb first, ninth bit if asked, stop held a full bit
	task automatic send(input logic [8:0] d, input logic nine, input logic stop);
		logic [10:0] bits;
		int n;
		bits = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
		n = nine ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge i_sys_clk);
			o_line <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		o_line <= 1'b1;
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
// self-checking bench for the serial receiver
module testbench import uart_rx_pkg::*;;
	localparam int BIT_CLKS = 32; // divisor 1, wide: tick every 2 clocks
	logic clk, rst_n, rd, wr, sleep;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic wait_rq, irq, wake, line;
	logic [7:0] b [3]; // random payload bytes
	logic [15:0] exp_q [$]; // mask and value noted per read
	int err_total, tests_run, seed;
	uart_rx_top uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd),
		.i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
		.o_waitrequest(wait_rq), .i_serial_receive_line(line), .i_sleep(sleep),
		.o_rx_irq(irq), .o_wake_req(wake));
	serial_tx_model #(.BIT_CLKS(BIT_CLKS)) partner (.i_sys_clk(clk), .o_line(line));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one access held until waitrequest is seen low; reads note their expectation
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [7:0] e = 8'h00, input logic [7:0] m = 8'h00);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h0, d};
		if (!w) exp_q.push_back({m, e});
		// no limit of its own: only the watchdog may end a stalled access
		do begin
			@(posedge clk);
		end while (wait_rq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// watcher: every completed read takes the oldest note
	always @(posedge clk) begin
		logic [15:0] note;
		if (rd && wait_rq === 1'b0 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			check("readdata", rdata[7:0] & note[15:8], note[7:0] & note[15:8]);
		end
	end
	// a frame plus one bit so the word has landed
	task automatic frame(input logic [8:0] d, input logic nine, input logic stop);
		partner.send(d, nine, stop);
		repeat (BIT_CLKS) @(posedge clk);
	endtask
	// watchdog sized well above the frame count
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial begin
		seed = 29;
		err_total = 0;
		tests_run = 0;
		rst_n = 1'b0;
		{rd, wr, sleep, addr, wdata} = '0;
		be = 4'h1;
		for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and a hole in the map
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h00, 8'hFF);
		bus(0, OFS_BAUD_CTRL, 0, 8'h40, 8'hFF);
		bus(0, 5'h1C, 0, 8'h00, 8'hFF);
		// setup; a write with no byte enable must not land
		bus(1, OFS_DIV_LOW, 8'h01);
		be <= 4'h0;
		bus(1, OFS_DIV_LOW, 8'h55);
		be <= 4'h1;
		bus(0, OFS_DIV_LOW, 0, 8'h01, 8'hFF);
		bus(1, OFS_BAUD_CTRL, 8'h08);
		bus(1, OFS_TX_STAT_CTRL, 8'h00);
		bus(1, OFS_IRQ_CTRL, 8'h01);
		bus(1, OFS_RX_STAT_CTRL, 8'h90);
		// three words back to back, idle bit sampled mid-frame
		fork
			for (int i = 0; i < 3; i++) partner.send({1'b0, b[i]}, 1'b0, 1'b1);
			begin
				repeat (BIT_CLKS * 3) @(posedge clk);
				bus(0, OFS_BAUD_CTRL, 0, 8'h00, 8'h40);
			end
		join
		repeat (BIT_CLKS) @(posedge clk);
		check("irq", {7'h0, irq}, 8'h01);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h02, 8'h06);
		bus(0, OFS_RX_BUFFER, 0, b[0], 8'hFF);
		bus(0, OFS_RX_BUFFER, 0, b[1], 8'hFF);
		bus(1, OFS_RX_STAT_CTRL, 8'h80);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h00, 8'h06);
		check("irq", {7'h0, irq}, 8'h00);
		// low stop bit; a stray start behind it is drained and discarded
		bus(1, OFS_RX_STAT_CTRL, 8'h90);
		frame({1'b0, b[2]}, 1'b0, 1'b0);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h04, 8'h04);
		bus(1, OFS_RX_STAT_CTRL, 8'h80);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h00, 8'h04);
		bus(0, OFS_RX_BUFFER, 0, b[2], 8'hFF);
		repeat (BIT_CLKS * 12) @(posedge clk);
		bus(0, OFS_RX_BUFFER, 0);
		// nine-bit address detect: data word withheld, address word kept
		bus(1, OFS_RX_STAT_CTRL, 8'hD8);
		frame({1'b0, b[0]}, 1'b1, 1'b1);
		check("irq", {7'h0, irq}, 8'h00);
		frame({1'b1, b[1]}, 1'b1, 1'b1);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h01, 8'h01);
		bus(0, OFS_RX_BUFFER, 0, b[1], 8'hFF);
		bus(1, OFS_RX_STAT_CTRL, 8'hD0);
		frame({1'b0, b[2]}, 1'b1, 1'b1);
		bus(0, OFS_RX_STAT_CTRL, 0, 8'h00, 8'h01);
		bus(0, OFS_RX_BUFFER, 0, b[2], 8'hFF);
		// nothing received asleep or with continuous enable off
		bus(1, OFS_RX_STAT_CTRL, 8'h90);
		sleep <= 1'b1;
		frame({1'b0, b[0]}, 1'b0, 1'b1);
		sleep <= 1'b0;
		check("irq", {7'h0, irq}, 8'h00);
		bus(1, OFS_RX_STAT_CTRL, 8'h80);
		frame({1'b0, b[1]}, 1'b0, 1'b1);
		check("irq", {7'h0, irq}, 8'h00);
		// wake on a falling edge while asleep, self-clear on the rise
		bus(1, OFS_RX_STAT_CTRL, 8'h90);
		bus(1, OFS_BAUD_CTRL, 8'h0A);
		sleep <= 1'b1;
		fork
			frame(9'h000, 1'b0, 1'b1);
			begin
				repeat (BIT_CLKS * 3) @(posedge clk);
				bus(0, OFS_BAUD_CTRL, 0, 8'h42, 8'h42);
			end
		join
		check("wake", {7'h0, wake}, 8'h01);
		check("irq", {7'h0, irq}, 8'h01);
		bus(0, OFS_BAUD_CTRL, 0, 8'h00, 8'h02);
		sleep <= 1'b0;
		bus(0, OFS_RX_BUFFER, 0);
		repeat (3) @(posedge clk);
		check("wake", {7'h0, wake}, 8'h00);
		check("irq", {7'h0, irq}, 8'h00);
		frame({1'b0, b[2]}, 1'b0, 1'b1);
		bus(0, OFS_RX_BUFFER, 0, b[2], 8'hFF);
		stop_test();
	end
endmodule
